//--- dv/pie_regs_tb_top.sv
// Self-checking testbench for the peripheral interrupt enable and priority register slice.
// Assumes the register port and event inputs are driven from the single 40 MHz core clock.
`timescale 1ns/10ps
module pie_regs_tb_top;

  // ==========================================================================
  // Signals
  logic                  clk_in;
  logic                  resetn_in;
  pie_pkg::pie_bus_req_s bus_in;
  logic [7:0]            rdata_out;
  logic [7:0]            ev1_in;
  logic [7:0]            ev2_in;
  logic [7:0]            prio2_in;
  logic [7:0]            enable2_out;
  logic [7:0]            prio_eff_out;
  logic                  two_level_out;
  logic                  irq_out;
  logic                  irq_high_out;
  logic                  irq_low_out;
  logic [7:0]            rd_val;
  int                    fails;
  int                    total_checks;

  pie_regs #(.SMALL_PKG(1'b0)) pie_regs_i (
    .clk_in        (clk_in),
    .resetn_in     (resetn_in),
    .bus_in        (bus_in),
    .rdata_out     (rdata_out),
    .ev1_in        (ev1_in),
    .ev2_in        (ev2_in),
    .prio2_in      (prio2_in),
    .enable2_out   (enable2_out),
    .prio_eff_out  (prio_eff_out),
    .two_level_out (two_level_out),
    .irq_out       (irq_out),
    .irq_high_out  (irq_high_out),
    .irq_low_out   (irq_low_out)
  );

  // ==========================================================================
  // Clock
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : wait_n

  task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    bus_in.wr <= 1'b0;
  endtask : bus_wr

  // Read data stand only in the cycle after the strobe, so it is sampled just past that edge.
  task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_in);
    bus_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    bus_in.rd <= 1'b0;
    #1;
    d = rdata_out;
  endtask : bus_rd

  task automatic pulse_ev(input logic [7:0] e1, input logic [7:0] e2);
    @(posedge clk_in);
    ev1_in <= e1;
    ev2_in <= e2;
    @(posedge clk_in);
    ev1_in <= 8'h00;
    ev2_in <= 8'h00;
  endtask : pulse_ev

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    bus_rd(pie_pkg::ADDR_ENABLE2, rd_val);
    chk(rd_val, 8'h00, "enable2 reset");
    bus_rd(pie_pkg::ADDR_PRIO1, rd_val);
    chk(rd_val, 8'hFF, "prio1 reset");
    wait_n(1);
    chk(rdata_out, 8'h00, "read data not held");
    chk({7'h00, two_level_out}, 8'h00, "levels off at reset");
    chk({7'h00, irq_out}, 8'h00, "no irq at reset");
  endtask : t_reset

  task automatic t_enable;
    bus_wr(pie_pkg::ADDR_ENABLE2, 8'hFF);
    bus_rd(pie_pkg::ADDR_ENABLE2, rd_val);
    chk(rd_val, 8'hDF, "enable2 gap bit");
    chk(enable2_out, 8'hDF, "enable2 copy");
    bus_wr(pie_pkg::ADDR_ENABLE2, 8'h20);
    bus_rd(pie_pkg::ADDR_ENABLE2, rd_val);
    chk(rd_val, 8'h00, "enable2 only gap bit written");
    @(posedge clk_in);
    bus_in <= '{addr: pie_pkg::ADDR_ENABLE2, wdata: 8'h81, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    bus_in <= '{addr: pie_pkg::ADDR_ENABLE2, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    bus_in <= '0;
    #1;
    chk(rdata_out, 8'h81, "read right behind write");
    bus_wr(4'hF, 8'hFF);
    bus_rd(4'hF, rd_val);
    chk(rd_val, 8'h00, "unmapped read");
  endtask : t_enable

  task automatic t_prio_bits;
    for (int i = 0; i < 8; i++) begin
      bus_wr(pie_pkg::ADDR_PRIO1, 8'h01 << i);
      bus_rd(pie_pkg::ADDR_PRIO1, rd_val);
      chk(rd_val, 8'h01 << i, "prio1 single bit");
      chk(prio_eff_out, 8'h00, "prio ignored, levels off");
    end
  endtask : t_prio_bits

  task automatic t_levels;
    bus_wr(pie_pkg::ADDR_PRIO1, 8'h5A);
    bus_wr(pie_pkg::ADDR_CTRL, 8'h80);
    wait_n(2);
    chk({7'h00, two_level_out}, 8'h01, "levels on");
    chk(prio_eff_out, 8'h5A, "prio shown, levels on");
    bus_wr(pie_pkg::ADDR_CTRL, 8'h00);
    wait_n(2);
    chk({7'h00, two_level_out}, 8'h00, "levels off");
    chk(prio_eff_out, 8'h00, "prio hidden, levels off");
  endtask : t_levels

  // A disabled source must stay silent while an enabled one routes by its priority.
  task automatic t_irq;
    bus_wr(pie_pkg::ADDR_ENABLE2, 8'h01);
    pulse_ev(8'h00, 8'h02);
    wait_n(2);
    chk({7'h00, irq_out}, 8'h00, "disabled source");
    bus_wr(pie_pkg::ADDR_STATUS2, 8'hFF);
    pulse_ev(8'h00, 8'h01);
    wait_n(2);
    chk({6'h00, irq_high_out, irq_low_out}, 8'h02, "single level all high");
    bus_wr(pie_pkg::ADDR_CTRL, 8'h80);
    wait_n(2);
    chk({6'h00, irq_high_out, irq_low_out}, 8'h01, "group 2 low");
    bus_wr(pie_pkg::ADDR_STATUS2, 8'h01);
    wait_n(2);
    chk({7'h00, irq_out}, 8'h00, "status cleared");
    bus_wr(pie_pkg::ADDR_MASK1, 8'h10);
    bus_wr(pie_pkg::ADDR_PRIO1, 8'hEF);
    pulse_ev(8'h10, 8'h00);
    wait_n(2);
    chk({6'h00, irq_high_out, irq_low_out}, 8'h01, "transmitter low");
    bus_wr(pie_pkg::ADDR_PRIO1, 8'h10);
    wait_n(2);
    chk({6'h00, irq_high_out, irq_low_out}, 8'h02, "transmitter high");
    bus_wr(pie_pkg::ADDR_STATUS1, 8'hFF);
    wait_n(2);
    chk({7'h00, irq_out}, 8'h00, "group 1 cleared");
    @(posedge clk_in);
    prio2_in <= 8'h01;
    pulse_ev(8'h00, 8'h01);
    wait_n(2);
    chk({6'h00, irq_high_out, irq_low_out}, 8'h02, "group 2 high");
    bus_wr(pie_pkg::ADDR_STATUS2, 8'h01);
    bus_wr(pie_pkg::ADDR_MASK1, 8'h0F);
    for (int i = 0; i < 4; i++) begin
      bus_wr(pie_pkg::ADDR_PRIO1, 8'h00);
      pulse_ev(8'h01 << i, 8'h00);
      wait_n(2);
      chk({6'h00, irq_high_out, irq_low_out}, 8'h01, "low-order source low");
      bus_wr(pie_pkg::ADDR_PRIO1, 8'h01 << i);
      wait_n(2);
      chk({6'h00, irq_high_out, irq_low_out}, 8'h02, "low-order source high");
      bus_wr(pie_pkg::ADDR_STATUS1, 8'h01 << i);
    end
    wait_n(2);
    chk({7'h00, irq_out}, 8'h00, "low-order sources cleared");
  endtask : t_irq

  // A reset in mid-run must bring back the power-on values over whatever was written.
  task automatic t_mid_reset;
    bus_wr(pie_pkg::ADDR_ENABLE2, 8'h5F);
    bus_wr(pie_pkg::ADDR_PRIO1, 8'h00);
    @(posedge clk_in);
    resetn_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    bus_rd(pie_pkg::ADDR_ENABLE2, rd_val);
    chk(rd_val, pie_pkg::ENABLE2_RESET, "enable2 after second reset");
    bus_rd(pie_pkg::ADDR_PRIO1, rd_val);
    chk(rd_val, pie_pkg::PRIO1_RESET, "prio1 after second reset");
    chk({7'h00, two_level_out}, 8'h00, "levels off after second reset");
    chk(prio_eff_out, 8'h00, "prio hidden after second reset");
  endtask : t_mid_reset

  // ==========================================================================
  // Ending
  task automatic test_done;
    $display("fails=%0d total_checks=%0d", fails, total_checks);
    if (fails == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done

  initial begin
    #100000;
    fails++;
    test_done();
  end

  initial begin
    fails        = 0;
    total_checks = 0;
    resetn_in    = 1'b0;
    bus_in       = '0;
    ev1_in       = 8'h00;
    ev2_in       = 8'h00;
    prio2_in     = 8'h00;
    repeat (8) @(posedge clk_in);
    resetn_in <= 1'b1;
    t_reset();
    t_enable();
    t_prio_bits();
    t_levels();
    t_irq();
    t_mid_reset();
    test_done();
  end

endmodule : pie_regs_tb_top

//--- logic/pie_pkg.sv
// Constants, field layout and carrier types of the peripheral interrupt enable and priority slice.
// Assumes a single 40 MHz core clock and a plain address/strobe register port driven by the core.
package pie_pkg;

  // ==========================================================================
  // Register port geometry
  localparam int          ADDR_W          = 4;
  localparam int          DATA_W          = 8;

  // ==========================================================================
  // Register offsets
  localparam logic [3:0]  ADDR_ENABLE2    = 4'h0;
  localparam logic [3:0]  ADDR_PRIO1      = 4'h1;
  localparam logic [3:0]  ADDR_CTRL       = 4'h2;
  localparam logic [3:0]  ADDR_STATUS1    = 4'h3;
  localparam logic [3:0]  ADDR_MASK1      = 4'h4;
  localparam logic [3:0]  ADDR_STATUS2    = 4'h5;

  // ==========================================================================
  // Enable register 2 field positions
  localparam int          OSC_FAIL_BIT    = 7;
  localparam int          COMPARATOR_BIT  = 6;
  localparam int          ENABLE2_GAP_BIT = 5;
  localparam int          NV_WRITE_BIT    = 4;
  localparam int          BUS_COLL_BIT    = 3;
  localparam int          VOLT_DET_BIT    = 2;
  localparam int          TIMER3_BIT      = 1;
  localparam int          CAPTURE2_BIT    = 0;
  localparam logic [7:0]  ENABLE2_IMPL    = 8'hDF;

  // ==========================================================================
  // Priority register 1 field positions
  localparam int          PAR_SLAVE_BIT   = 7;
  localparam int          ANALOG_BIT      = 6;
  localparam int          SERIAL_RX_BIT   = 5;
  localparam int          SERIAL_TX_BIT   = 4;
  localparam int          SYNC_SERIAL_BIT = 3;
  localparam int          CAPTURE1_BIT    = 2;
  localparam int          TIMER2_BIT      = 1;
  localparam int          TIMER1_BIT      = 0;
  localparam logic [7:0]  PRIO1_FULL_IMPL = 8'hFF;
  localparam logic [7:0]  PRIO1_SMALL_IMPL = 8'h7F;

  // ==========================================================================
  // Control register field positions
  localparam int          PRIO_EN_BIT     = 7;
  localparam logic [7:0]  CTRL_IMPL       = 8'h80;

  // ==========================================================================
  // Reset values
  localparam logic [7:0]  ENABLE2_RESET   = 8'h00;
  localparam logic [7:0]  PRIO1_RESET     = 8'hFF;
  localparam logic [7:0]  CTRL_RESET      = 8'h00;
  localparam logic [7:0]  MASK1_RESET     = 8'h00;
  localparam logic [7:0]  STATUS_RESET    = 8'h00;
  localparam logic [7:0]  RDATA_RESET     = 8'h00;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pie_bus_req_s;

  typedef struct packed {
    logic any;
    logic high;
    logic low;
  } pie_irq_s;

endpackage : pie_pkg

//--- logic/pie_regs.sv
// Peripheral interrupt enable register 2, priority register 1 and the priority routing they steer.
// Assumes the core drives the register port synchronously and that event inputs are one-cycle pulses.
//
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/10ps

// Functional notes
// - Per-source enable bits; bit 5 reads zero
// - Per-source priority bit: one high, zero low
// - Priority bits ignored while priority levels disabled
// - Bit 4 is serial transmitter priority
// - Bit 3 is synchronous serial priority
// - Bit 2 is capture unit 1 priority
// - Bit 1 is timer 2 match priority
// - Bit 0 is timer 1 overflow priority
// - Global enable: two levels, else single level
module pie_regs #(
  parameter bit SMALL_PKG = 1'b0
) (
  // Clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 resetn_in,
  // Register port
  input  wire pie_pkg::pie_bus_req_s bus_in,
  output logic                [7:0] rdata_out,
  // Peripheral events, group 1 and group 2
  input  wire logic           [7:0] ev1_in,
  input  wire logic           [7:0] ev2_in,
  // Priority of group 2 sources, held by a neighbouring register
  input  wire logic           [7:0] prio2_in,
  // Register state shown to the core
  output logic                [7:0] enable2_out,
  output logic                [7:0] prio_eff_out,
  output logic                      two_level_out,
  // Interrupt requests
  output logic                      irq_out,
  output logic                      irq_high_out,
  output logic                      irq_low_out
);

  // ==========================================================================
  // Local signals
  localparam logic [7:0] PRIO1_IMPL = SMALL_PKG ? pie_pkg::PRIO1_SMALL_IMPL : pie_pkg::PRIO1_FULL_IMPL;

  logic [7:0]        enable2;
  logic [7:0]        prio1;
  logic [7:0]        ctrl;
  logic [7:0]        mask1;
  logic [7:0]        status1;
  logic [7:0]        status2;
  logic [7:0]        clr1;
  logic [7:0]        clr2;
  logic [7:0]        set1;
  logic [7:0]        set2;
  logic [7:0]        pend1;
  logic [7:0]        pend2;
  logic [7:0]        next_rdata;
  logic              prio_en;
  logic              wr_enable2;
  logic              wr_prio1;
  logic              wr_ctrl;
  logic              wr_mask1;
  logic              wr_status1;
  logic              wr_status2;
  pie_pkg::pie_irq_s next_irq;
  logic              rd_q;
  logic [3:0]        rd_addr_q;

  // ==========================================================================
  // Address decode
  always_comb begin
    wr_enable2 = bus_in.wr && (bus_in.addr == pie_pkg::ADDR_ENABLE2);
    wr_prio1   = bus_in.wr && (bus_in.addr == pie_pkg::ADDR_PRIO1);
    wr_ctrl    = bus_in.wr && (bus_in.addr == pie_pkg::ADDR_CTRL);
    wr_mask1   = bus_in.wr && (bus_in.addr == pie_pkg::ADDR_MASK1);
    wr_status1 = bus_in.wr && (bus_in.addr == pie_pkg::ADDR_STATUS1);
    wr_status2 = bus_in.wr && (bus_in.addr == pie_pkg::ADDR_STATUS2);
  end

  // ==========================================================================
  // Enable register 2
  // The gap bit is never stored, so it cannot read back as one.
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      enable2 <= pie_pkg::ENABLE2_RESET;
    end else if (wr_enable2) begin
      enable2 <= bus_in.wdata & pie_pkg::ENABLE2_IMPL;
    end
  end

  // ==========================================================================
  // Priority register 1
  // On the small package the parallel slave port is absent and its bit stays zero.
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      prio1 <= pie_pkg::PRIO1_RESET & PRIO1_IMPL;
    end else if (wr_prio1) begin
      prio1 <= bus_in.wdata & PRIO1_IMPL;
    end
  end

  // ==========================================================================
  // Control register with the global priority-levels enable
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      ctrl <= pie_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= bus_in.wdata & pie_pkg::CTRL_IMPL;
    end
  end

  always_comb begin
    prio_en = ctrl[pie_pkg::PRIO_EN_BIT];
  end

  // ==========================================================================
  // Mask for group 1 events
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      mask1 <= pie_pkg::MASK1_RESET;
    end else if (wr_mask1) begin
      mask1 <= bus_in.wdata & PRIO1_IMPL;
    end
  end

  // ==========================================================================
  // Sticky event status, cleared by writing ones
  always_comb begin
    set1 = ev1_in & PRIO1_IMPL;
    set2 = ev2_in & pie_pkg::ENABLE2_IMPL;
    clr1 = wr_status1 ? bus_in.wdata : 8'h00;
    clr2 = wr_status2 ? bus_in.wdata : 8'h00;
  end

  pie_sticky_w1c #(
    .W (8)
  ) u_status1 (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .set_in    (set1),
    .clr_in    (clr1),
    .flags_out (status1)
  );

  pie_sticky_w1c #(
    .W (8)
  ) u_status2 (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .set_in    (set2),
    .clr_in    (clr2),
    .flags_out (status2)
  );

  // ==========================================================================
  // Priority routing
  // With levels disabled every pending source lands on the single, high vector.
  always_comb begin
    pend1 = status1 & mask1;
    pend2 = status2 & enable2;
    next_irq.any = (|pend1) || (|pend2);
    if (prio_en) begin
      next_irq.high = (|(pend1 & prio1)) || (|(pend2 & prio2_in));
      next_irq.low  = (|(pend1 & ~prio1)) || (|(pend2 & ~prio2_in));
    end else begin
      next_irq.high = next_irq.any;
      next_irq.low  = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      irq_out      <= 1'b0;
      irq_high_out <= 1'b0;
      irq_low_out  <= 1'b0;
    end else begin
      irq_out      <= next_irq.any;
      irq_high_out <= next_irq.high;
      irq_low_out  <= next_irq.low;
    end
  end

  // ==========================================================================
  // Register state outputs
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      enable2_out   <= pie_pkg::ENABLE2_RESET;
      prio_eff_out  <= 8'h00;
      two_level_out <= 1'b0;
    end else begin
      enable2_out   <= enable2;
      prio_eff_out  <= prio_en ? prio1 : 8'h00;
      two_level_out <= prio_en;
    end
  end

  // ==========================================================================
  // Read path, data one cycle after the strobe
  always_comb begin
    next_rdata = 8'h00;
    if (bus_in.rd) begin
      unique case (bus_in.addr)
        pie_pkg::ADDR_ENABLE2: next_rdata = enable2;
        pie_pkg::ADDR_PRIO1:   next_rdata = prio1;
        pie_pkg::ADDR_CTRL:    next_rdata = ctrl;
        pie_pkg::ADDR_STATUS1: next_rdata = status1;
        pie_pkg::ADDR_MASK1:   next_rdata = mask1;
        pie_pkg::ADDR_STATUS2: next_rdata = status2;
        default:               next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      rdata_out <= pie_pkg::RDATA_RESET;
    end else begin
      rdata_out <= next_rdata;
    end
  end

  // Remembers the last read for the checks below only.
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      rd_q      <= 1'b0;
      rd_addr_q <= 4'h0;
    end else begin
      rd_q      <= bus_in.rd;
      rd_addr_q <= bus_in.addr;
    end
  end

  // ==========================================================================
  // Checks
  a_gap_reads_zero: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (rd_q && (rd_addr_q == pie_pkg::ADDR_ENABLE2)) |-> (rdata_out[pie_pkg::ENABLE2_GAP_BIT] == 1'b0))
    else $error("enable register gap bit read as one");

  a_enable_write_readback: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (wr_enable2 ##1 (bus_in.rd && !bus_in.wr && (bus_in.addr == pie_pkg::ADDR_ENABLE2)))
    |=> (rdata_out == ($past(bus_in.wdata, 2) & pie_pkg::ENABLE2_IMPL)))
    else $error("enable register did not read back the written value");

  a_enable_gates_irq: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ((enable2 == 8'h00) && (mask1 == 8'h00)) |=> !irq_out)
    else $error("interrupt raised with every source disabled");

  a_prio_write_takes: assert property (@(posedge clk_in) disable iff (!resetn_in)
    wr_prio1 |=> (prio1 == ($past(bus_in.wdata) & PRIO1_IMPL)))
    else $error("priority register ignored a write");

  a_prio_ignored_off: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (!prio_en && next_irq.any) |=> (irq_high_out && !irq_low_out && (prio_eff_out == 8'h00)))
    else $error("priority bits acted while levels were disabled");

  a_tx_low_route: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (prio_en && (pend2 == 8'h00) && (pend1 != 8'h00) && ((pend1 & prio1) == 8'h00)) |=> (irq_low_out && !irq_high_out))
    else $error("low priority source reached the high request");

  a_tx_high_route: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (prio_en && pend1[pie_pkg::SERIAL_TX_BIT] && prio1[pie_pkg::SERIAL_TX_BIT]) |=> irq_high_out)
    else $error("high priority transmitter event missed the high request");

  a_timer1_high_route: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (prio_en && (pend1 & prio1 & 8'h0F) != 8'h00) |=> irq_high_out)
    else $error("high priority low-order source missed the high request");

  a_two_level_flag: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (wr_ctrl && bus_in.wdata[pie_pkg::PRIO_EN_BIT]) |=> ##1 two_level_out)
    else $error("two-level mode did not follow the control write");

  a_small_pkg_zero: assert property (@(posedge clk_in) disable iff (!resetn_in)
    SMALL_PKG |-> (prio1[pie_pkg::PAR_SLAVE_BIT] == 1'b0))
    else $error("parallel slave priority set on the small package");

  a_reset_values: assert property (@(posedge clk_in)
    (!$past(resetn_in) && resetn_in) |-> ((enable2 == 8'h00) && (prio1 == (pie_pkg::PRIO1_RESET & PRIO1_IMPL))))
    else $error("registers left reset with wrong values");

  a_reset_outputs: assert property (@(posedge clk_in)
    (!$past(resetn_in) && resetn_in) |-> (!irq_out && !irq_high_out && !irq_low_out && !two_level_out
      && (enable2_out == pie_pkg::ENABLE2_RESET) && (prio_eff_out == 8'h00)))
    else $error("outputs left reset with wrong values");

  // ==========================================================================
  // Register file checks
  // The gap bit is watched in the stored state as well as on reads, so a stray one cannot hide.
  a_enable_gap_clear: assert property (@(posedge clk_in) disable iff (!resetn_in)
    enable2[pie_pkg::ENABLE2_GAP_BIT] == 1'b0)
    else $error("enable register stored a one in its gap bit");

  a_status_gap_clear: assert property (@(posedge clk_in) disable iff (!resetn_in)
    status2[pie_pkg::ENABLE2_GAP_BIT] == 1'b0)
    else $error("status register stored a one in its gap bit");

  a_enable_write_takes: assert property (@(posedge clk_in) disable iff (!resetn_in)
    wr_enable2 |=> (enable2 == ($past(bus_in.wdata) & pie_pkg::ENABLE2_IMPL)))
    else $error("enable register ignored a write");

  a_ctrl_write_takes: assert property (@(posedge clk_in) disable iff (!resetn_in)
    wr_ctrl |=> (prio_en == $past(bus_in.wdata[pie_pkg::PRIO_EN_BIT])))
    else $error("priority levels enable ignored a write");

  a_read_one_cycle: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !bus_in.rd |=> (rdata_out == 8'h00))
    else $error("read data stood without a read strobe");

  a_eff_follows_prio: assert property (@(posedge clk_in) disable iff (!resetn_in)
    prio_en |=> (prio_eff_out == $past(prio1)))
    else $error("shown priority did not follow the priority register");

  a_levels_low_quiet: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !prio_en |=> !irq_low_out)
    else $error("low request raised while levels were disabled");

  // ==========================================================================
  // Per-source routing checks
  // Each low-order source is followed on its own, so a wrong bit position shows up as a missed request.
  a_sync_serial_low: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (prio_en && pend1[pie_pkg::SYNC_SERIAL_BIT] && !prio1[pie_pkg::SYNC_SERIAL_BIT]) |=> irq_low_out)
    else $error("low priority synchronous serial event missed the low request");

  a_capture1_low_route: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (prio_en && pend1[pie_pkg::CAPTURE1_BIT] && !prio1[pie_pkg::CAPTURE1_BIT]) |=> irq_low_out)
    else $error("low priority capture unit 1 event missed the low request");

  a_timer2_low_route: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (prio_en && pend1[pie_pkg::TIMER2_BIT] && !prio1[pie_pkg::TIMER2_BIT]) |=> irq_low_out)
    else $error("low priority timer 2 match event missed the low request");

  a_timer1_low_route: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (prio_en && pend1[pie_pkg::TIMER1_BIT] && !prio1[pie_pkg::TIMER1_BIT]) |=> irq_low_out)
    else $error("low priority timer 1 overflow event missed the low request");

  a_group2_high_route: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (prio_en && ((pend2 & prio2_in) != 8'h00)) |=> irq_high_out)
    else $error("high priority group 2 event missed the high request");

  a_group2_low_route: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (prio_en && ((pend2 & ~prio2_in) != 8'h00)) |=> irq_low_out)
    else $error("low priority group 2 event missed the low request");

endmodule : pie_regs

//--- logic/pie_sticky_w1c.sv
// Bank of sticky event flags, set by hardware pulses and cleared by writing ones.
// Assumes set and clear inputs are synchronous to the clock and already qualified by address.
`timescale 1ns/10ps
module pie_sticky_w1c #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         resetn_in,
  // Set and clear
  input  wire logic [W-1:0] set_in,
  input  wire logic [W-1:0] clr_in,
  // Flags
  output logic      [W-1:0] flags_out
);

  logic [W-1:0] next_flags;

  // A set in the same cycle as its clear wins, so no event is lost.
  always_comb begin
    next_flags = (flags_out & ~clr_in) | set_in;
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      flags_out <= '0;
    end else begin
      flags_out <= next_flags;
    end
  end

  // ==========================================================================
  // Checks
  a_set_wins_clear: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (set_in != '0) |=> ((flags_out & $past(set_in)) == $past(set_in)))
    else $error("sticky flag lost an event against its clear");

  a_clear_drops_flag: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (clr_in != '0) |=> ((flags_out & $past(clr_in) & ~$past(set_in)) == '0))
    else $error("sticky flag survived a clear without a set");

endmodule : pie_sticky_w1c
